// file: pkg/usb_tx_endpoint_one_pkg.sv
// Purpose: Shared constants and types for the endpoint one transmit logic.
// Assumes: Byte-wide payload stream and a 16-bit core register bus.
// Notes: Register offsets are full core bus byte addresses.
package usb_tx_endpoint_one_pkg;

  // --------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------
  localparam logic [31:0] CONFIG_ADDR = 32'h5000_1850;
  localparam logic [31:0] FIFO_PORT_ADDR = 32'h5000_1852;
  localparam logic [31:0] STATUS_ADDR = 32'h5000_1854;
  localparam int CFG_STALL_BIT = 7;
  localparam int CFG_ISO_BIT = 5;
  localparam int CFG_ACTIVE_BIT = 4;
  localparam int STAT_UNDERFLOW_BIT = 7;
  localparam int STAT_ACK_BIT = 6;
  localparam int STAT_DONE_BIT = 5;
  localparam logic [4:0] FREE_COUNT_MAX = 5'h1f;
  localparam int TX_FIFO_DEPTH = 32;

  // --------------------------------------------------------------------
  // Packet identifiers and CRC
  // --------------------------------------------------------------------
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_SETUP = 4'hd;
  localparam logic [3:0] PID_DATA0 = 4'h3;
  localparam logic [3:0] PID_DATA1 = 4'hb;
  localparam logic [3:0] PID_ACK = 4'h2;
  localparam logic [3:0] PID_NAK = 4'ha;
  localparam logic [3:0] PID_STALL = 4'he;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY_REFLECTED = 16'ha001;

  // --------------------------------------------------------------------
  // Transmit sequencer states
  // --------------------------------------------------------------------
  typedef enum logic [7:0] {
    TX_IDLE = 8'h01,
    TX_PID = 8'h02,
    TX_DATA = 8'h04,
    TX_CRC_LO = 8'h08,
    TX_CRC_HI = 8'h10,
    TX_EOP = 8'h20,
    TX_STUFF = 8'h40,
    TX_WAIT_HS = 8'h80
  } tx_state_type;

endpackage

// file: pkg/byte_fifo_if.sv
// Purpose: Valid/ready carrier between the endpoint logic and its FIFO.
// Assumes: Both sides run on the same clock.
// Notes: Flush empties the buffer in one cycle.
`timescale 1ns/1ps
interface byte_fifo_if #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) ();
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  logic flush;
  logic [$clog2(DEPTH+1)-1:0] used;

  modport buffer (
    input push_valid, push_data, pop_ready, flush,
    output push_ready, pop_valid, pop_data, used
  );
  modport user (
    output push_valid, push_data, pop_ready, flush,
    input push_ready, pop_valid, pop_data, used
  );
endinterface

// file: design/tx_byte_fifo.sv
// Purpose: Parameterised synchronous FIFO for transmit payload bytes.
// Assumes: Single clock, synchronous active-high reset.
// Notes: A push while full is refused through push_ready.
`timescale 1ns/1ps
module tx_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Buffer side of the carrier.
  byte_fifo_if.buffer fifo
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } fifo_state_type;

  fifo_state_type s_q, s_d;
  logic do_push;
  logic do_pop;

  // Honest full and empty come straight from the occupancy count.
  assign fifo.push_ready = (s_q.count != CW'(DEPTH));
  assign fifo.pop_valid = (s_q.count != '0);
  assign fifo.pop_data = s_q.mem[s_q.rd_ptr];
  assign fifo.used = s_q.count;
  assign do_push = fifo.push_valid && fifo.push_ready;
  assign do_pop = fifo.pop_ready && fifo.pop_valid;

  // Next state: pointers wrap at DEPTH so any depth works.
  always_comb begin
    s_d = s_q;
    if (do_push) begin
      s_d.mem[s_q.wr_ptr] = fifo.push_data;
      s_d.wr_ptr = (s_q.wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(s_q.wr_ptr + 1'b1);
    end
    if (do_pop) begin
      s_d.rd_ptr = (s_q.rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(s_q.rd_ptr + 1'b1);
    end
    s_d.count = CW'(s_q.count + CW'(do_push) - CW'(do_pop));
    if (fifo.flush) begin
      s_d.wr_ptr = '0;
      s_d.rd_ptr = '0;
      s_d.count = '0;
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  a_fifo_push_step: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    do_push && !do_pop && !fifo.flush |=> s_q.count == $past(s_q.count) + 1'b1)
    else $error("FIFO count did not grow by one on a push.");
endmodule

// file: design/usb_tx_endpoint_one.sv
// Purpose: Configuration, status and transmit sequencing for endpoint one.
// Assumes: Token, frame and handshake inputs come from on-chip logic on clk_i.
// Notes: Bus read data appears one cycle after the read strobe.
`timescale 1ns/1ps
module usb_tx_endpoint_one #(
  parameter int FIFO_DEPTH = usb_tx_endpoint_one_pkg::TX_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Core register bus.
  input wire logic [31:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [15:0] bus_wdata_i,
  output logic [15:0] bus_rdata_o,
  output logic tx_fifo_ready_o,
  // Settings held in neighbouring registers.
  input wire logic [6:0] function_address_i,
  input wire logic tx_enable_i,
  input wire logic rx_enable_i,
  input wire logic toggle_i,
  input wire logic last_byte_i,
  input wire logic iso_frame_match_bypass_i,
  input wire logic test_mode_i,
  // Token and frame events from the receive side.
  input wire logic token_valid_i,
  input wire logic [3:0] token_pid_i,
  input wire logic [6:0] token_addr_i,
  input wire logic [3:0] token_endpoint_i,
  input wire logic sof_i,
  input wire logic frame_lsb_i,
  input wire logic host_ack_i,
  input wire logic host_timeout_i,
  // Outgoing byte stream to the serialiser.
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  output logic tx_stuff_err_o,
  output logic tx_eop_o,
  // Handshake request to the serialiser.
  output logic handshake_valid_o,
  output logic [3:0] handshake_pid_o
);
  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    usb_tx_endpoint_one_pkg::tx_state_type state;
    logic stall;
    logic iso;
    logic endpoint_active;
    logic [3:0] endpoint_number;
    logic tx_underflow_flag;
    logic ack_status;
    logic tx_done;
    logic iso_sent;
    logic [15:0] crc;
    logic out_valid;
    logic [7:0] out_data;
    logic eop;
    logic stuff_err;
    logic hs_valid;
    logic [3:0] hs_pid;
    logic [15:0] rdata;
  } endpoint_state_type;

  endpoint_state_type s_q, s_d;
  byte_fifo_if #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) fifo ();

  logic token_match;
  logic frame_ok;
  logic can_load;
  logic tx_pop;
  logic bus_pop;
  logic [4:0] tx_free_count;
  logic [3:0] data_pid;
  int unsigned free_bytes;

  // --------------------------------------------------------------------
  // Payload FIFO
  // --------------------------------------------------------------------
  tx_byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .fifo(fifo.buffer)
  );

  // Firmware pushes payload bytes only; a write while full is dropped.
  assign fifo.push_valid = bus_wr_i && (bus_addr_i == usb_tx_endpoint_one_pkg::FIFO_PORT_ADDR);
  assign fifo.push_data = bus_wdata_i[7:0];
  assign fifo.pop_ready = tx_pop || bus_pop;
  assign tx_fifo_ready_o = fifo.push_ready;

  // Free space saturates so a deep FIFO still fits the five-bit field.
  assign free_bytes = FIFO_DEPTH - int'(fifo.used);
  assign tx_free_count = (free_bytes > 31) ? usb_tx_endpoint_one_pkg::FREE_COUNT_MAX
                         : 5'(free_bytes);

  // Address match only counts while the endpoint is active.
  assign token_match = token_valid_i && s_q.endpoint_active
                       && token_addr_i == function_address_i
                       && token_endpoint_i == s_q.endpoint_number;

  // An iso packet may go out only in its scheduled frame unless bypassed.
  assign frame_ok = iso_frame_match_bypass_i || (frame_lsb_i == toggle_i);
  assign can_load = !s_q.out_valid || tx_ready_i;
  assign data_pid = (s_q.iso || !toggle_i) ? usb_tx_endpoint_one_pkg::PID_DATA0
                    : usb_tx_endpoint_one_pkg::PID_DATA1;

  // CRC16 over one byte, least significant bit first as sent on the wire.
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc_in, input logic [7:0] data);
    logic [15:0] c;
    c = crc_in;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ data[i]) begin
        c = (c >> 1) ^ usb_tx_endpoint_one_pkg::CRC_POLY_REFLECTED;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  // Register effects come first so that any hardware set later wins.
  always_comb begin
    s_d = s_q;
    tx_pop = 1'b0;
    bus_pop = 1'b0;
    fifo.flush = 1'b0;
    s_d.eop = 1'b0;
    s_d.stuff_err = 1'b0;
    s_d.hs_valid = 1'b0;
    if (tx_ready_i) begin
      s_d.out_valid = 1'b0;
    end
    if (bus_wr_i && bus_addr_i == usb_tx_endpoint_one_pkg::CONFIG_ADDR) begin
      s_d.stall = bus_wdata_i[usb_tx_endpoint_one_pkg::CFG_STALL_BIT];
      s_d.iso = bus_wdata_i[usb_tx_endpoint_one_pkg::CFG_ISO_BIT];
      s_d.endpoint_active = bus_wdata_i[usb_tx_endpoint_one_pkg::CFG_ACTIVE_BIT];
      s_d.endpoint_number = bus_wdata_i[3:0];
    end
    if (bus_rd_i) begin
      s_d.rdata = 16'h0000;
      case (bus_addr_i)
        usb_tx_endpoint_one_pkg::CONFIG_ADDR: begin
          s_d.rdata = {8'h00, s_q.stall, 1'b0, s_q.iso, s_q.endpoint_active,
                       s_q.endpoint_number};
        end
        usb_tx_endpoint_one_pkg::FIFO_PORT_ADDR: begin
          // Read-back is a test aid only; it must not steal bytes mid-packet.
          if (test_mode_i && s_q.state == usb_tx_endpoint_one_pkg::TX_IDLE) begin
            s_d.rdata = {8'h00, fifo.pop_data};
            bus_pop = fifo.pop_valid;
          end
        end
        usb_tx_endpoint_one_pkg::STATUS_ADDR: begin
          s_d.rdata = {8'h00, s_q.tx_underflow_flag, s_q.ack_status, s_q.tx_done,
                       tx_free_count};
          s_d.tx_underflow_flag = 1'b0;
          s_d.ack_status = 1'b0;
          s_d.tx_done = 1'b0;
        end
        default: begin
          s_d.rdata = 16'h0000;
        end
      endcase
    end
    case (s_q.state)
      usb_tx_endpoint_one_pkg::TX_IDLE: begin
        // A missed iso frame is discarded at the next frame start.
        if (sof_i) begin
          s_d.iso_sent = 1'b0;
          if (s_q.iso && tx_enable_i && frame_ok && !s_q.iso_sent) begin
            s_d.ack_status = 1'b0;
            fifo.flush = 1'b1;
            s_d.tx_done = 1'b1;
          end
        end
        if (token_match && token_pid_i == usb_tx_endpoint_one_pkg::PID_IN) begin
          if (s_q.stall && tx_enable_i) begin
            s_d.hs_valid = 1'b1;
            s_d.hs_pid = usb_tx_endpoint_one_pkg::PID_STALL;
            s_d.tx_done = 1'b1;
          end else if (tx_enable_i && (!s_q.iso || frame_ok)
                       && (fifo.pop_valid || last_byte_i)) begin
            s_d.state = usb_tx_endpoint_one_pkg::TX_PID;
          end else if (!s_q.iso) begin
            s_d.hs_valid = 1'b1;
            s_d.hs_pid = usb_tx_endpoint_one_pkg::PID_NAK;
          end
        end else if (token_match && token_pid_i == usb_tx_endpoint_one_pkg::PID_OUT) begin
          if (s_q.stall && rx_enable_i) begin
            s_d.hs_valid = 1'b1;
            s_d.hs_pid = usb_tx_endpoint_one_pkg::PID_STALL;
          end
        end
        // SETUP and foreign tokens get nothing from this endpoint.
      end
      usb_tx_endpoint_one_pkg::TX_PID: begin
        if (can_load) begin
          s_d.out_valid = 1'b1;
          s_d.out_data = {~data_pid, data_pid};
          s_d.crc = usb_tx_endpoint_one_pkg::CRC_INIT;
          s_d.state = usb_tx_endpoint_one_pkg::TX_DATA;
        end
      end
      usb_tx_endpoint_one_pkg::TX_DATA: begin
        if (can_load) begin
          if (fifo.pop_valid) begin
            tx_pop = 1'b1;
            s_d.out_valid = 1'b1;
            s_d.out_data = fifo.pop_data;
            s_d.crc = crc16_byte(s_q.crc, fifo.pop_data);
          end else if (last_byte_i) begin
            s_d.state = usb_tx_endpoint_one_pkg::TX_CRC_LO;
          end else begin
            s_d.state = usb_tx_endpoint_one_pkg::TX_STUFF;
          end
        end
      end
      usb_tx_endpoint_one_pkg::TX_CRC_LO: begin
        if (can_load) begin
          s_d.out_valid = 1'b1;
          s_d.out_data = ~s_q.crc[7:0];
          s_d.state = usb_tx_endpoint_one_pkg::TX_CRC_HI;
        end
      end
      usb_tx_endpoint_one_pkg::TX_CRC_HI: begin
        if (can_load) begin
          s_d.out_valid = 1'b1;
          s_d.out_data = ~s_q.crc[15:8];
          s_d.state = usb_tx_endpoint_one_pkg::TX_EOP;
        end
      end
      usb_tx_endpoint_one_pkg::TX_STUFF: begin
        // Wait for the last good byte to leave before corrupting the packet.
        if (!s_q.out_valid) begin
          s_d.stuff_err = 1'b1;
          s_d.tx_underflow_flag = 1'b1;
          s_d.state = usb_tx_endpoint_one_pkg::TX_EOP;
        end
      end
      usb_tx_endpoint_one_pkg::TX_EOP: begin
        if (!s_q.out_valid) begin
          s_d.eop = 1'b1;
          if (s_q.iso) begin
            s_d.iso_sent = 1'b1;
            s_d.ack_status = 1'b1;
            s_d.tx_done = 1'b1;
            s_d.state = usb_tx_endpoint_one_pkg::TX_IDLE;
          end else begin
            s_d.state = usb_tx_endpoint_one_pkg::TX_WAIT_HS;
          end
        end
      end
      usb_tx_endpoint_one_pkg::TX_WAIT_HS: begin
        if (host_ack_i) begin
          s_d.ack_status = 1'b1;
          s_d.tx_done = 1'b1;
          s_d.state = usb_tx_endpoint_one_pkg::TX_IDLE;
        end else if (host_timeout_i) begin
          s_d.ack_status = 1'b0;
          s_d.tx_done = 1'b1;
          s_d.state = usb_tx_endpoint_one_pkg::TX_IDLE;
        end
      end
      default: begin
        s_d.state = usb_tx_endpoint_one_pkg::TX_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // State register and outputs
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
      s_q.state <= usb_tx_endpoint_one_pkg::TX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // All outputs but tx_fifo_ready_o come straight from the state register.
  assign bus_rdata_o = s_q.rdata;
  assign tx_valid_o = s_q.out_valid;
  assign tx_data_o = s_q.out_data;
  assign tx_stuff_err_o = s_q.stuff_err;
  assign tx_eop_o = s_q.eop;
  assign handshake_valid_o = s_q.hs_valid;
  assign handshake_pid_o = s_q.hs_pid;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_stall_in_token: assert property (token_match && token_pid_i == usb_tx_endpoint_one_pkg::PID_IN
    && s_q.state == usb_tx_endpoint_one_pkg::TX_IDLE && s_q.stall && tx_enable_i
    |=> handshake_valid_o && handshake_pid_o == usb_tx_endpoint_one_pkg::PID_STALL)
    else $error("IN token with stall set did not get STALL.");

  a_setup_no_stall: assert property (token_valid_i
    && token_pid_i == usb_tx_endpoint_one_pkg::PID_SETUP |=> !handshake_valid_o)
    else $error("SETUP token produced a handshake.");

  a_iso_no_nak: assert property (handshake_valid_o && $past(s_q.iso)
    |-> handshake_pid_o != usb_tx_endpoint_one_pkg::PID_NAK)
    else $error("Isochronous endpoint sent NAK.");

  a_inactive_silent: assert property (token_valid_i && !s_q.endpoint_active
    && s_q.state == usb_tx_endpoint_one_pkg::TX_IDLE
    |=> !handshake_valid_o && s_q.state == usb_tx_endpoint_one_pkg::TX_IDLE)
    else $error("Inactive endpoint responded to a token.");

  a_number_write: assert property (bus_wr_i && bus_addr_i == usb_tx_endpoint_one_pkg::CONFIG_ADDR
    |=> s_q.endpoint_number == $past(bus_wdata_i[3:0]))
    else $error("Endpoint number did not take the written value.");

  a_pid_leads: assert property ($rose(tx_valid_o) && $past(s_q.state == usb_tx_endpoint_one_pkg::TX_PID)
    |-> tx_data_o[3:0] == ~tx_data_o[7:4])
    else $error("First byte of a packet is not a PID.");

  a_stuff_then_eop: assert property (tx_stuff_err_o |-> s_q.tx_underflow_flag ##1 tx_eop_o)
    else $error("Underflow did not give flag then end-of-packet.");

  a_status_read_clear: assert property (bus_rd_i && bus_addr_i == usb_tx_endpoint_one_pkg::STATUS_ADDR
    && s_q.state == usb_tx_endpoint_one_pkg::TX_IDLE && !token_valid_i && !sof_i
    |=> !s_q.tx_underflow_flag && !s_q.ack_status && !s_q.tx_done)
    else $error("Status read did not clear the flags.");

  a_ack_sets_done: assert property (host_ack_i && s_q.state == usb_tx_endpoint_one_pkg::TX_WAIT_HS
    |=> s_q.ack_status && s_q.tx_done)
    else $error("Host ACK was not recorded.");
endmodule

// file: bench/usb_host_model.sv
// Purpose: Far side of the transmit stream, standing in for serialiser and host.
// Assumes: Same clock as the endpoint; the bench chooses ACK or silence.
// Notes: Keeps the latest eight captured bytes, indexed by a byte count that runs on across packets.
`timescale 1ns/1ps
module usb_host_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Control from the bench.
  input wire logic clr_i,
  input wire logic ack_en_i,
  input wire logic slow_i,
  // Stream from the endpoint.
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic stuff_i,
  input wire logic eop_i,
  output logic tx_ready_o,
  output logic host_ack_o,
  output logic host_timeout_o,
  // Capture for the bench.
  output logic [7:0] seen_o [8],
  output logic [3:0] n_bytes_o,
  output logic [3:0] n_stuff_o
);
  logic [1:0] wait_q;
  // A slow host drops ready every other cycle so the endpoint must hold its byte.
  always @(posedge clk_i) begin
    host_ack_o <= 1'b0;
    host_timeout_o <= 1'b0;
    tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
    if (sys_rst_i || clr_i) begin
      n_bytes_o <= 4'h0;
      n_stuff_o <= 4'h0;
      wait_q <= 2'h0;
      tx_ready_o <= 1'b0;
    end else begin
      if (tx_valid_i && tx_ready_o) begin
        seen_o[n_bytes_o[2:0]] <= tx_data_i;
        n_bytes_o <= n_bytes_o + 4'h1;
      end
      if (stuff_i) n_stuff_o <= n_stuff_o + 4'h1;
      if (eop_i) wait_q <= 2'h2;
      else if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
      if (wait_q == 2'h1) begin
        host_ack_o <= ack_en_i;
        host_timeout_o <= ~ack_en_i;
      end
    end
  end
endmodule

// file: bench/test_usb_tx_endpoint_one.sv
// Purpose: Self-checking bench for the endpoint one transmit logic.
// Assumes: Full 32-byte FIFO so the saturated free count can be seen.
// Notes: Tokens are driven directly; the host model answers data packets.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, a); end end
module test_usb_tx_endpoint_one;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, bus_wr_i, bus_rd_i, tx_fifo_ready_o, tx_enable_i;
  logic rx_enable_i, toggle_i, last_byte_i, iso_frame_match_bypass_i, test_mode_i;
  logic token_valid_i, sof_i, frame_lsb_i, host_ack_i, host_timeout_i, tx_valid_o;
  logic tx_ready_i, tx_stuff_err_o, tx_eop_o, handshake_valid_o, clr, ack_en, slow;
  logic [31:0] bus_addr_i;
  logic [15:0] bus_wdata_i, bus_rdata_o, rd;
  logic [6:0] function_address_i, token_addr_i;
  logic [3:0] token_pid_i, token_endpoint_i, handshake_pid_o, hs_pid, n_bytes, n_stuff;
  logic [7:0] tx_data_o;
  logic [7:0] seen [8];
  int n_errors = 0, total_checks = 0, n_hs = 0;

  // ----------------------------------------------------------------
  // Design, far side and clock
  // ----------------------------------------------------------------
  usb_tx_endpoint_one u_dut (.clk_i, .sys_rst_i, .bus_addr_i, .bus_wr_i, .bus_rd_i,
    .bus_wdata_i, .bus_rdata_o, .tx_fifo_ready_o, .function_address_i, .tx_enable_i,
    .rx_enable_i, .toggle_i, .last_byte_i, .iso_frame_match_bypass_i, .test_mode_i,
    .token_valid_i, .token_pid_i, .token_addr_i, .token_endpoint_i, .sof_i, .frame_lsb_i,
    .host_ack_i, .host_timeout_i, .tx_valid_o, .tx_data_o, .tx_ready_i, .tx_stuff_err_o,
    .tx_eop_o, .handshake_valid_o, .handshake_pid_o);
  usb_host_model u_host (.clk_i, .sys_rst_i, .clr_i(clr), .ack_en_i(ack_en), .slow_i(slow),
    .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .stuff_i(tx_stuff_err_o),
    .eop_i(tx_eop_o), .tx_ready_o(tx_ready_i), .host_ack_o(host_ack_i),
    .host_timeout_o(host_timeout_i), .seen_o(seen), .n_bytes_o(n_bytes), .n_stuff_o(n_stuff));
  always #25 clk_i = ~clk_i;
  // Handshake pulses last one cycle, so they are counted at every edge.
  always @(posedge clk_i) if (handshake_valid_o === 1'b1) begin
    n_hs <= n_hs + 1;
    hs_pid <= handshake_pid_o;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus_addr_i <= a;
    bus_wdata_i <= d;
    bus_wr_i <= 1'b1;
    @(posedge clk_i);
    bus_wr_i <= 1'b0;
  endtask
  task automatic rdr(input logic [31:0] a);
    @(posedge clk_i);
    bus_addr_i <= a;
    bus_rd_i <= 1'b1;
    @(posedge clk_i);
    bus_rd_i <= 1'b0;
    #1 rd = bus_rdata_o;
  endtask
  // Silence can only be judged after a spell longer than any answer takes.
  task automatic tok(input logic [3:0] p, input logic [6:0] a, input logic [3:0] e);
    @(posedge clk_i);
    token_valid_i <= 1'b1;
    token_pid_i <= p;
    token_addr_i <= a;
    token_endpoint_i <= e;
    @(posedge clk_i);
    token_valid_i <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask
  task automatic wait_end();
    for (int i = 0; i < 100 && !(host_ack_i || host_timeout_i); i++) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
  endtask
  function automatic logic [15:0] crc_of(input logic [15:0] d);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < 16; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    return ~c;
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {bus_addr_i, bus_wr_i, bus_rd_i, bus_wdata_i, tx_enable_i, rx_enable_i, toggle_i} = '0;
    {last_byte_i, iso_frame_match_bypass_i, test_mode_i, token_valid_i, sof_i} = '0;
    {frame_lsb_i, token_pid_i, token_addr_i, token_endpoint_i, clr, ack_en, slow} = '0;
    function_address_i = 7'h11;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rdr(usb_tx_endpoint_one_pkg::CONFIG_ADDR); `CHK("config", 16'h0000, rd)
    rdr(usb_tx_endpoint_one_pkg::STATUS_ADDR); `CHK("status", 16'h001f, rd)
    rdr(32'h5000_1856); `CHK("unmapped", 16'h0000, rd)
    wr(usb_tx_endpoint_one_pkg::CONFIG_ADDR, 16'hffff);
    rdr(usb_tx_endpoint_one_pkg::CONFIG_ADDR); `CHK("config", 16'h00bf, rd)
    wr(usb_tx_endpoint_one_pkg::CONFIG_ADDR, 16'h0003);
    tok(usb_tx_endpoint_one_pkg::PID_IN, 7'h11, 4'h3); `CHK("hs", 0, n_hs)
    `CHK("bytes", 4'h0, n_bytes)
    $display("test reset and config done");
    wr(usb_tx_endpoint_one_pkg::CONFIG_ADDR, 16'h0093);
    tx_enable_i <= 1'b1;
    rx_enable_i <= 1'b1;
    tok(usb_tx_endpoint_one_pkg::PID_IN, 7'h11, 4'h3); `CHK("hs", 1, n_hs)
    `CHK("hs pid", usb_tx_endpoint_one_pkg::PID_STALL, hs_pid)
    tok(usb_tx_endpoint_one_pkg::PID_SETUP, 7'h11, 4'h3); `CHK("hs", 1, n_hs)
    tok(usb_tx_endpoint_one_pkg::PID_OUT, 7'h11, 4'h3); `CHK("hs", 2, n_hs)
    tok(usb_tx_endpoint_one_pkg::PID_IN, 7'h12, 4'h3); `CHK("hs", 2, n_hs)
    rdr(usb_tx_endpoint_one_pkg::STATUS_ADDR); `CHK("status", 16'h003f, rd)
    rdr(usb_tx_endpoint_one_pkg::STATUS_ADDR); `CHK("status", 16'h001f, rd)
    $display("test stall done");
    wr(usb_tx_endpoint_one_pkg::CONFIG_ADDR, 16'h0013);
    wr(usb_tx_endpoint_one_pkg::FIFO_PORT_ADDR, 16'h005a);
    wr(usb_tx_endpoint_one_pkg::FIFO_PORT_ADDR, 16'h0001);
    rdr(usb_tx_endpoint_one_pkg::STATUS_ADDR); `CHK("status", 16'h001e, rd)
    last_byte_i <= 1'b1;
    ack_en <= 1'b1;
    slow <= 1'b1;
    tok(usb_tx_endpoint_one_pkg::PID_IN, 7'h11, 4'h3);
    wait_end();
    `CHK("bytes", 4'h5, n_bytes)
    `CHK("pid", 8'hc3, seen[0])
    `CHK("payload", 16'h015a, {seen[2], seen[1]})
    `CHK("crc", crc_of(16'h015a), {seen[4], seen[3]})
    rdr(usb_tx_endpoint_one_pkg::STATUS_ADDR); `CHK("status", 16'h007f, rd)
    $display("test data packet done");
    last_byte_i <= 1'b0;
    ack_en <= 1'b0;
    slow <= 1'b0;
    toggle_i <= 1'b1;
    wr(usb_tx_endpoint_one_pkg::FIFO_PORT_ADDR, 16'h0077);
    tok(usb_tx_endpoint_one_pkg::PID_IN, 7'h11, 4'h3);
    wait_end();
    `CHK("stuff", 4'h1, n_stuff)
    rdr(usb_tx_endpoint_one_pkg::STATUS_ADDR); `CHK("underflow", 1'b1, rd[7])
    `CHK("status", 16'h00bf, rd)
    `CHK("data1 pid", 8'h4b, seen[5])
    $display("test underflow done");
    for (int i = 0; i < 33; i++) wr(usb_tx_endpoint_one_pkg::FIFO_PORT_ADDR, 16'(64 + i));
    `CHK("ready", 1'b0, tx_fifo_ready_o)
    rdr(usb_tx_endpoint_one_pkg::STATUS_ADDR); `CHK("status", 16'h0000, rd)
    rdr(usb_tx_endpoint_one_pkg::FIFO_PORT_ADDR); `CHK("port", 16'h0000, rd)
    test_mode_i <= 1'b1;
    rdr(usb_tx_endpoint_one_pkg::FIFO_PORT_ADDR); `CHK("port", 16'h0040, rd)
    test_mode_i <= 1'b0;
    rdr(usb_tx_endpoint_one_pkg::STATUS_ADDR); `CHK("status", 16'h0001, rd)
    $display("test fill done");
    wr(usb_tx_endpoint_one_pkg::CONFIG_ADDR, 16'h0033);
    iso_frame_match_bypass_i <= 1'b1;
    @(posedge clk_i) sof_i <= 1'b1;
    @(posedge clk_i) sof_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rdr(usb_tx_endpoint_one_pkg::STATUS_ADDR); `CHK("status", 16'h003f, rd)
    tok(usb_tx_endpoint_one_pkg::PID_IN, 7'h11, 4'h3); `CHK("hs", 2, n_hs)
    wr(usb_tx_endpoint_one_pkg::FIFO_PORT_ADDR, 16'h00a5);
    last_byte_i <= 1'b1;
    tok(usb_tx_endpoint_one_pkg::PID_IN, 7'h11, 4'h3); `CHK("bytes", 4'hb, n_bytes)
    `CHK("iso pid", 8'hc3, seen[7])
    rdr(usb_tx_endpoint_one_pkg::STATUS_ADDR); `CHK("status", 16'h007f, rd)
    $display("test iso done");
    stop_test();
  end
  // A hang is cut short well past the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    stop_test();
  end
endmodule
